/* odpc_pkg.sv */
// Package: register map, field layout and reset values of the output driver pop control block
package odpc_pkg;
    // Register offsets as printed; 0x5e is not a multiple of four, so these are indices
    localparam logic [7:0] HP_CTRL_INDEX   = 8'h5a;
    localparam logic [7:0] LINE_CTRL_INDEX = 8'h5e;
    localparam int         ADDR_WIDTH      = 10;
    localparam int         DATA_WIDTH      = 32;
    localparam int         REG_WIDTH       = 16;
    // Byte addresses are four times the index
    localparam logic [ADDR_WIDTH-1:0] HP_CTRL_ADDR   = {HP_CTRL_INDEX, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] LINE_CTRL_ADDR = {LINE_CTRL_INDEX, 2'h0};
    // Field positions inside one channel nibble; left nibble sits at CH_LEFT_BASE
    localparam int BIT_IN_STAGE    = 0;
    localparam int BIT_MID_STAGE   = 1;
    localparam int BIT_OUT_STAGE   = 2;
    localparam int BIT_SHORT_REL   = 3;
    localparam int CH_RIGHT_BASE   = 0;
    localparam int CH_LEFT_BASE    = 4;
    localparam int CH_BITS         = 4;
    localparam int FIELD_BITS      = 8;
    localparam logic [FIELD_BITS-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 32'h0000_0000;
    // Avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Bus slave sequencing
    typedef enum logic [0:0] {ODPC_IDLE, ODPC_ACK} odpc_bus_state_type;
endpackage

/* odpc_stage_if.sv */
// Interface: one channel's four stage controls from the register bank to its driver decode
`timescale 1ns/100ps
interface odpc_stage_if;
    logic [3:0] fields;
    logic       in_on;
    logic       mid_on;
    logic       out_on;
    logic       short_release;
    modport bank (output fields, input in_on, mid_on, out_on, short_release);
    modport drv  (input fields, output in_on, mid_on, out_on, short_release);
endinterface

/* odpc_channel.sv */
// Per-channel stage control flip-flops driving one output driver
`timescale 1ns/100ps
module odpc_channel (
    input  wire logic   ref_clk,
    input  wire logic   sys_rst,
    odpc_stage_if.drv   ch
);
    ////////////////////////////////////////////////////////////////////////
    // Fields go to the stages with no ordering of their own, each through one flop (one edge of delay)
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ch.in_on         <= 1'h0;
            ch.mid_on        <= 1'h0;
            ch.out_on        <= 1'h0;
            ch.short_release <= 1'h0;
        end else begin
            ch.in_on         <= ch.fields[odpc_pkg::BIT_IN_STAGE];
            ch.mid_on        <= ch.fields[odpc_pkg::BIT_MID_STAGE];
            ch.out_on        <= ch.fields[odpc_pkg::BIT_OUT_STAGE];
            ch.short_release <= ch.fields[odpc_pkg::BIT_SHORT_REL];
        end
    end

    // Output follows its field one edge later
    a_stage_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 ch.out_on == $past(ch.fields[odpc_pkg::BIT_OUT_STAGE]))
        else $error("output stage does not follow its field");
endmodule

/* odpc_driver_ctrl.sv */
// Top: output driver pop control register bank on an Avalon-MM slave
`timescale 1ns/100ps
// Behaviour
// - 0x5a bit 7: left headphone short released when 1, shorted when 0
// - 0x5a bit 6: left headphone output stage enable
// - 0x5a bit 5: left headphone intermediate stage enable
// - 0x5a bit 4: left headphone input stage enable
// - 0x5a bits 3..0: same layout for right headphone
// - 0x5e bits 7..4: left line output short release and three stage enables
// - 0x5e bits 3..0: right line output, same order and polarity
// - After reset all fields read 0: stages off, outputs shorted
module odpc_driver_ctrl (
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    input  wire logic [odpc_pkg::ADDR_WIDTH-1:0]  avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [odpc_pkg::DATA_WIDTH-1:0]  avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic      [odpc_pkg::DATA_WIDTH-1:0]  avs_readdata,
    output logic                                  avs_waitrequest,
    output logic      [1:0]                       avs_response,
    output logic                                  hp_left_short_release,
    output logic                                  hp_left_out_stage_on,
    output logic                                  hp_left_mid_stage_on,
    output logic                                  hp_left_in_stage_on,
    output logic                                  hp_right_short_release,
    output logic                                  hp_right_out_stage_on,
    output logic                                  hp_right_mid_stage_on,
    output logic                                  hp_right_in_stage_on,
    output logic                                  line_left_short_release,
    output logic                                  line_left_out_stage_on,
    output logic                                  line_left_mid_stage_on,
    output logic                                  line_left_in_stage_on,
    output logic                                  line_right_short_release,
    output logic                                  line_right_out_stage_on,
    output logic                                  line_right_mid_stage_on,
    output logic                                  line_right_in_stage_on
);
    localparam int NUM_CH = 4;

    logic [odpc_pkg::FIELD_BITS-1:0] hp_ctrl_q;
    logic [odpc_pkg::FIELD_BITS-1:0] line_ctrl_q;
    odpc_pkg::odpc_bus_state_type    bus_state_q;
    logic                            hit_hp;
    logic                            hit_line;
    logic                            do_write;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign hit_hp   = (avs_address == odpc_pkg::HP_CTRL_ADDR);
    assign hit_line = (avs_address == odpc_pkg::LINE_CTRL_ADDR);
    // Write commits at the edge where waitrequest is seen low
    assign do_write = avs_write && (bus_state_q == odpc_pkg::ODPC_ACK);

    // Two-phase slave: first cycle stalls, second cycle answers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_state_q <= odpc_pkg::ODPC_IDLE;
        end else begin
            case (bus_state_q)
                odpc_pkg::ODPC_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_q <= odpc_pkg::ODPC_ACK;
                    end
                end
                odpc_pkg::ODPC_ACK: begin
                    bus_state_q <= odpc_pkg::ODPC_IDLE;
                end
                default: begin
                    bus_state_q <= odpc_pkg::ODPC_IDLE;
                end
            endcase
        end
    end

    // Waitrequest from a flop: low only in the answer cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'h1;
        end else begin
            avs_waitrequest <= !((bus_state_q == odpc_pkg::ODPC_IDLE) && (avs_read || avs_write));
        end
    end

    // Read data and response prepared while stalled, so they stand when waitrequest drops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= odpc_pkg::UNMAPPED_READ;
            avs_response <= odpc_pkg::RESP_OKAY;
        end else if (bus_state_q == odpc_pkg::ODPC_IDLE) begin
            avs_response <= (hit_hp || hit_line) ? odpc_pkg::RESP_OKAY : odpc_pkg::RESP_SLVERR;
            if (avs_read && hit_hp) begin
                avs_readdata <= {{(odpc_pkg::DATA_WIDTH-odpc_pkg::FIELD_BITS){1'h0}}, hp_ctrl_q};
            end else if (avs_read && hit_line) begin
                avs_readdata <= {{(odpc_pkg::DATA_WIDTH-odpc_pkg::FIELD_BITS){1'h0}}, line_ctrl_q};
            end else begin
                avs_readdata <= odpc_pkg::UNMAPPED_READ; // Unmapped and upper bits read zero
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Headphone register; only byte lane 0 holds fields
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hp_ctrl_q <= odpc_pkg::CTRL_RESET;
        end else if (do_write && hit_hp && avs_byteenable[0]) begin
            hp_ctrl_q <= avs_writedata[odpc_pkg::FIELD_BITS-1:0];
        end
    end

    // Line output register; no order checked, software owns the sequence
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_ctrl_q <= odpc_pkg::CTRL_RESET;
        end else if (do_write && hit_line && avs_byteenable[0]) begin
            line_ctrl_q <= avs_writedata[odpc_pkg::FIELD_BITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One stage-control slice per channel: hp right, hp left, line right, line left
    odpc_stage_if ch_if [NUM_CH] ();
    logic [odpc_pkg::FIELD_BITS*2-1:0] all_fields;
    logic [NUM_CH-1:0] in_v;
    logic [NUM_CH-1:0] mid_v;
    logic [NUM_CH-1:0] out_v;
    logic [NUM_CH-1:0] sr_v;
    assign all_fields = {line_ctrl_q, hp_ctrl_q};

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign ch_if[c].fields = all_fields[c*odpc_pkg::CH_BITS +: odpc_pkg::CH_BITS];
        assign in_v[c]  = ch_if[c].in_on;
        assign mid_v[c] = ch_if[c].mid_on;
        assign out_v[c] = ch_if[c].out_on;
        assign sr_v[c]  = ch_if[c].short_release;
        odpc_channel u_ch (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ch      (ch_if[c])
        );
    end

    // Driver pins come straight from the slice flops
    assign hp_right_in_stage_on      = in_v[0];
    assign hp_right_mid_stage_on     = mid_v[0];
    assign hp_right_out_stage_on     = out_v[0];
    assign hp_right_short_release    = sr_v[0];
    assign hp_left_in_stage_on       = in_v[1];
    assign hp_left_mid_stage_on      = mid_v[1];
    assign hp_left_out_stage_on      = out_v[1];
    assign hp_left_short_release     = sr_v[1];
    assign line_right_in_stage_on    = in_v[2];
    assign line_right_mid_stage_on   = mid_v[2];
    assign line_right_out_stage_on   = out_v[2];
    assign line_right_short_release  = sr_v[2];
    assign line_left_in_stage_on     = in_v[3];
    assign line_left_mid_stage_on    = mid_v[3];
    assign line_left_out_stage_on    = out_v[3];
    assign line_left_short_release   = sr_v[3];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_hp_write;
        avs_write && !avs_waitrequest && hit_hp && avs_byteenable[0];
    endsequence
    sequence s_line_write;
        avs_write && !avs_waitrequest && hit_line && avs_byteenable[0];
    endsequence

    a_hp_short_left: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hp_write |-> ##2 hp_left_short_release == $past(avs_writedata[7], 2))
        else $error("left headphone short release mismatch");
    a_hp_out_left: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hp_write |-> ##2 hp_left_out_stage_on == $past(avs_writedata[6], 2))
        else $error("left headphone output stage mismatch");
    a_hp_mid_left: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hp_write |-> ##2 hp_left_mid_stage_on == $past(avs_writedata[5], 2))
        else $error("left headphone mid stage mismatch");
    a_hp_in_left: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hp_write |-> ##2 hp_left_in_stage_on == $past(avs_writedata[4], 2))
        else $error("left headphone input stage mismatch");
    a_hp_right_nib: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hp_write |-> ##2 {hp_right_short_release, hp_right_out_stage_on, hp_right_mid_stage_on,
            hp_right_in_stage_on} == $past(avs_writedata[3:0], 2))
        else $error("right headphone nibble mismatch");
    a_line_left_nib: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_line_write |-> ##2 {line_left_short_release, line_left_out_stage_on, line_left_mid_stage_on,
            line_left_in_stage_on} == $past(avs_writedata[7:4], 2))
        else $error("left line nibble mismatch");
    a_line_right_nib: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_line_write |-> ##2 {line_right_short_release, line_right_out_stage_on, line_right_mid_stage_on,
            line_right_in_stage_on} == $past(avs_writedata[3:0], 2))
        else $error("right line nibble mismatch");
    a_reset_zero: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> hp_ctrl_q == odpc_pkg::CTRL_RESET && line_ctrl_q == odpc_pkg::CTRL_RESET
            && !hp_left_short_release && !line_right_short_release)
        else $error("fields not cleared by reset");
    a_bus_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");

    // Refused writes must leave the pop sequence where software last put it
    a_write_refused: assert property (@(posedge ref_clk) disable iff (sys_rst)
        avs_write && !avs_waitrequest && !(avs_byteenable[0] && (hit_hp || hit_line))
            |=> $stable(hp_ctrl_q) && $stable(line_ctrl_q))
        else $error("refused write changed a register");
    a_hp_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
        avs_read && !avs_waitrequest && hit_hp
            |-> avs_readdata == {{(odpc_pkg::DATA_WIDTH-odpc_pkg::FIELD_BITS){1'h0}}, hp_ctrl_q})
        else $error("headphone read back mismatch");
    a_line_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
        avs_read && !avs_waitrequest && hit_line
            |-> avs_readdata == {{(odpc_pkg::DATA_WIDTH-odpc_pkg::FIELD_BITS){1'h0}}, line_ctrl_q})
        else $error("line read back mismatch");
    a_unmapped_err: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (avs_read || avs_write) && !avs_waitrequest && !hit_hp && !hit_line
            |-> avs_response == odpc_pkg::RESP_SLVERR && avs_readdata == odpc_pkg::UNMAPPED_READ)
        else $error("unmapped access not refused");
endmodule

/* output_driver_pop_control_bench.sv */
// Self-checking testbench for the output driver pop control register bank
`timescale 1ns/100ps
module output_driver_pop_control_bench;
    typedef struct packed { logic rd; logic [31:0] data; logic [1:0] resp; } odpc_note_type;
    localparam logic [9:0] HP   = odpc_pkg::HP_CTRL_ADDR;
    localparam logic [9:0] LINE = odpc_pkg::LINE_CTRL_ADDR;
    localparam logic [9:0] HOLE = 10'h16c;
    logic          ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [9:0]    avs_address;
    logic [31:0]   avs_writedata, avs_readdata;
    logic [3:0]    avs_byteenable;
    logic [1:0]    avs_response;
    wire  [15:0]   stages;
    logic [7:0]    hp_m, line_m;
    int            n_errors, checks_done;
    odpc_note_type notes[$];
    logic [7:0]    steps[6] = '{8'h11, 8'h33, 8'h77, 8'hff, 8'h77, 8'h00};

    odpc_driver_ctrl dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .hp_left_short_release(stages[15]), .hp_left_out_stage_on(stages[14]),
        .hp_left_mid_stage_on(stages[13]), .hp_left_in_stage_on(stages[12]),
        .hp_right_short_release(stages[11]), .hp_right_out_stage_on(stages[10]),
        .hp_right_mid_stage_on(stages[9]), .hp_right_in_stage_on(stages[8]),
        .line_left_short_release(stages[7]), .line_left_out_stage_on(stages[6]),
        .line_left_mid_stage_on(stages[5]), .line_left_in_stage_on(stages[4]),
        .line_right_short_release(stages[3]), .line_right_out_stage_on(stages[2]),
        .line_right_mid_stage_on(stages[1]), .line_right_in_stage_on(stages[0]));

    // Free-running 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer; the note is queued before the request goes out
    task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        odpc_note_type n;
        n.rd   = !wr;
        n.resp = (a === HP || a === LINE) ? odpc_pkg::RESP_OKAY : odpc_pkg::RESP_SLVERR;
        n.data = {24'h0, (a === HP) ? hp_m : (a === LINE) ? line_m : 8'h00};
        notes.push_back(n);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        // Only the watchdog ends a wait that never sees waitrequest low
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // Lane 0 alone carries the fields; other lanes never gate a write
        if (wr && be[0] && a === HP) hp_m = d[7:0];
        if (wr && be[0] && a === LINE) line_m = d[7:0];
    endtask

    // Outputs lag the register by a clock, so let two edges pass
    task automatic chk_out();
        repeat (2) @(posedge ref_clk);
        check("stage outputs", {16'h0, hp_m, line_m}, {16'h0, stages});
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Answer watcher: takes the oldest note whenever a transfer completes
    always @(posedge ref_clk) begin
        odpc_note_type n;
        if ((avs_read === 1'b1 || avs_write === 1'b1) && avs_waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("ERROR answer expected none seen one");
            end else begin
                n = notes.pop_front();
                check("response", {30'h0, n.resp}, {30'h0, avs_response});
                if (n.rd) check("read data", n.data, avs_readdata);
            end
        end
    end

    // Watchdog far beyond the roughly 700 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        ref_clk = 1'b0; sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = '0; avs_writedata = '0; avs_byteenable = '0; hp_m = 8'h00; line_m = 8'h00;
        void'($urandom(29582));
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check("stage outputs at reset", 32'h0, {16'h0, stages});
        access(1'b0, HP, 32'h0, 4'h0);
        access(1'b0, LINE, 32'h0, 4'h0);
        $display("Test reset values done");
        // Walking one, mirrored between the two registers
        for (int i = 0; i < 8; i++) begin
            access(1'b1, HP, 32'h1 << i, 4'h1);
            access(1'b1, LINE, 32'h80 >> i, 4'h1);
            chk_out();
            access(1'b0, HP, 32'h0, 4'h0);
            access(1'b0, LINE, 32'h0, 4'h0);
        end
        $display("Test field map done");
        // Documented power-up then power-down, 20us before the middle stages
        foreach (steps[i]) begin
            access(1'b1, HP, {24'h0, steps[i]}, 4'hf);
            access(1'b1, LINE, {24'h0, steps[i]}, 4'hf);
            if (i == 0) repeat (200) @(posedge ref_clk);
            chk_out();
        end
        $display("Test ordered sequence done");
        // Out of order: headphone shorts released with every stage off, line right fully on, line left off, applied as written
        access(1'b1, HP, 32'h88, 4'h1);
        access(1'b1, LINE, 32'h0f, 4'h1);
        chk_out();
        // Refused writes and the unmapped hole
        access(1'b1, HP, 32'h5a, 4'he);
        access(1'b1, HOLE, 32'hff, 4'hf);
        access(1'b0, HOLE, 32'h0, 4'h0);
        access(1'b0, HP, 32'h0, 4'h0);
        chk_out();
        $display("Test refusals done");
        // Random traffic, one write and one read per round
        for (int i = 0; i < 40; i++) begin
            access(1'b1, ($urandom % 2) ? HP : LINE, $urandom, 4'($urandom));
            access(1'b0, ($urandom % 2) ? HP : LINE, 32'h0, 4'h0);
            chk_out();
        end
        $display("Test random traffic done");
        check("pending notes", 32'h0, notes.size());
        finish_test();
    end
endmodule
